/* File: common/tds_pkg.sv */
// package for the trap data transfer sequencer: widths and the period states
// assumes one master clock pulse input marks each period boundary
package tds_pkg;
   localparam int TDS_WORD_W = 18;

   // idle stands for period 1; the others are the clock periods of a trap
   typedef enum logic [2:0] {
      TDS_IDLE,
      TDS_P2,
      TDS_P3,
      TDS_P4,
      TDS_P5,
      TDS_P6,
      TDS_P7,
      TDS_P8
   } tds_period_t;

   typedef struct packed {
      tds_period_t period;
      logic        inhibit_clock;
      logic        acknowledge;
      logic        acknowledge_control;
      logic        timing_one;
      logic        timing_two;
      logic        write_latch;
      logic        dir_in;
   } tds_state_t;

   localparam tds_state_t TDS_RESET_STATE = '{
      period              : TDS_IDLE,
      inhibit_clock       : 1'b0,
      acknowledge         : 1'b0,
      acknowledge_control : 1'b0,
      timing_one          : 1'b0,
      timing_two          : 1'b0,
      write_latch         : 1'b0,
      dir_in              : 1'b0
   };
endpackage

/* File: verilog/tds_sequencer.sv */
// trap data transfer sequencer: eight-period trap-out and trap-in transfers
// assumes master_clock_pulse_i is a one-cycle pulse at the trailing edge of the
// master clock; every other input is synchronous to sys_clk_i
`timescale 1ns/1ps

// Operation
// - accept a trap in period 1 with phase clock, execute phase, request, no inhibit
// - inhibit clock sets starting period 2, holds for trap, selects arithmetic bus
// - acknowledge follows inhibit clock until end of period 7; interrupt clock mirrors it
// - acknowledge control and timing one set at the edge starting period 3
// - timing one without timing two gives address in, clear, receive, L load
// - period 4 function ready with master clock gives clear W and memory start
// - each memory cycle takes four periods; trap-out word reaches W early
// - trap-out period 5: timing two drives clear, data out and bus drive
// - timing one sets again starting period 6, enabling phase clock for period 7
// - trap-out period 7 data ready, shortened so function ready falls first
// - trap-out period 8 edge clears acknowledge and timing; inhibit clears after 8
// - trap-in repeats trap-out to period 3 and still starts a period 4 cycle
// - trap-in period 5: data in, bus receive, half cycle, write and load W enable
// - trap-in edge starting period 6 sets the write latch for periods 6 and 7
// - trap-in period 7 data ready loads W and starts the storing half cycle
// - trap-in period 8 edge clears acknowledge, timing and write latch
// - W bar bits inverted, gated with data out enable, ORed onto A bus
// - a sequence completes at the end of its eighth period
// - with full cycle false memory needs two starts, deferring the trap-in write
// - address code zero during a halt inhibits trap requests
// - detect at the first master clock with phase clock, execute phase and request
// - trap request is trap output request or trap input request
module tds_sequencer
   import tds_pkg::*;
#(
   parameter int WORD_W = TDS_WORD_W
)
(
   input  wire logic              sys_clk_i,              // system clock, 125 MHz
   input  wire logic              reset_i,                // synchronous reset, high
   input  wire logic              halt_reset_i,           // reset on halt
   input  wire logic              system_reset_i,         // front panel system reset
   input  wire logic              halt_i,                 // processor halted
   input  wire logic              master_clock_pulse_i,   // master clock trailing edge
   input  wire logic              phase_clock_i,          // processor phase clock
   input  wire logic              execute_phase_i,        // execute phase
   input  wire logic              address_code_zero_i,    // address code digit zero
   input  wire logic              other_inhibit_i,        // any other trap inhibit
   input  wire logic              trap_output_request_i,  // trap-out request, I/O bus
   input  wire logic              trap_input_request_i,   // trap-in request, I/O bus
   input  wire logic [WORD_W-1:0] w_reg_bar_i,            // W register bar outputs
   output logic                   inhibit_clock_o,        // inhibit clock flip-flop
   output logic                   arith_bus_select_o,     // selects arithmetic bus
   output logic                   clock_suppress_o,       // blocks clocks one, two, phase
   output logic                   acknowledge_o,          // acknowledge flip-flop
   output logic                   interrupt_clock_o,      // external interrupt clock
   output logic                   acknowledge_control_o,  // acknowledge control
   output logic                   timing_one_o,           // timing one flip-flop
   output logic                   timing_two_o,           // timing two flip-flop
   output logic                   phase_clock_gate_o,     // phase clock gate
   output logic                   address_in_o,           // trap address input
   output logic                   arith_clear_receive_o,  // clear arithmetic unit
   output logic                   bus_receive_gate_o,     // E bus onto C bus
   output logic                   load_l_register_o,      // load L register
   output logic                   function_ready_o,       // function ready to controller
   output logic                   clear_w_o,              // clear W pulse
   output logic                   start_memory_clock_o,   // memory start pulse
   output logic                   data_out_enable_o,      // W onto A bus
   output logic                   bus_drive_o,            // E bus drive
   output logic                   bus_drive_gate_o,       // C bus onto I/O bus
   output logic                   data_ready_o,           // data ready strobe
   output logic                   data_in_enable_o,       // trap data in
   output logic                   bus_receive_o,          // E bus receive
   output logic                   full_cycle_o,           // low means half cycle
   output logic                   write_latch_o,          // memory write latch
   output logic                   load_w_o,               // load W from C bus
   output logic [WORD_W-1:0]      a_bus_o                 // A bus contribution
);

   tds_state_t st_reg;
   tds_state_t st_next;
   logic       trap_request;
   logic       trap_inhibit;
   logic       clear_all;

   assign trap_request = trap_output_request_i | trap_input_request_i;
   // a halt with address code zero stops traps; an active sequence blocks new ones
   assign trap_inhibit = (halt_i & address_code_zero_i) | other_inhibit_i
                       | st_reg.inhibit_clock;
   assign clear_all    = reset_i | halt_reset_i | system_reset_i;

   always_comb
   begin
      st_next = st_reg;
      if (master_clock_pulse_i)
      begin
         case (st_reg.period)
            TDS_IDLE:
            begin
               if (phase_clock_i && execute_phase_i && trap_request
                   && !trap_inhibit)
               begin
                  st_next.period        = TDS_P2;
                  st_next.inhibit_clock = 1'b1;
                  st_next.acknowledge   = 1'b1;
                  st_next.dir_in        = trap_input_request_i & ~trap_output_request_i;
               end
            end
            TDS_P2:
            begin
               st_next.period              = TDS_P3;
               st_next.acknowledge_control = 1'b1;
               st_next.timing_one          = 1'b1;
            end
            TDS_P3:
               st_next.period = TDS_P4;
            TDS_P4:
            begin
               st_next.period     = TDS_P5;
               st_next.timing_one = 1'b0;
               st_next.timing_two = 1'b1;
            end
            TDS_P5:
            begin
               st_next.period      = TDS_P6;
               st_next.timing_one  = 1'b1;
               st_next.write_latch = st_reg.dir_in;
            end
            TDS_P6:
               st_next.period = TDS_P7;
            TDS_P7:
            begin
               // acknowledge control lets acknowledge drop while inhibit clock holds
               st_next.period              = TDS_P8;
               st_next.acknowledge         = ~st_reg.acknowledge_control;
               st_next.acknowledge_control = 1'b0;
               st_next.timing_one          = 1'b0;
               st_next.timing_two          = 1'b0;
               st_next.write_latch         = 1'b0;
            end
            TDS_P8:
               st_next = TDS_RESET_STATE;
            default:
               st_next = TDS_RESET_STATE;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (clear_all)
         st_reg <= TDS_RESET_STATE;
      else
         st_reg <= st_next;
   end

   logic in_p4;
   logic in_p7;
   logic out_t2;
   logic in_t2;

   assign in_p4  = (st_reg.period == TDS_P4);
   assign in_p7  = (st_reg.period == TDS_P7);
   assign out_t2 = st_reg.timing_two & ~st_reg.dir_in;
   assign in_t2  = st_reg.timing_two & st_reg.dir_in;

   assign inhibit_clock_o       = st_reg.inhibit_clock;
   assign arith_bus_select_o    = st_reg.inhibit_clock;
   assign clock_suppress_o      = st_reg.inhibit_clock;
   assign acknowledge_o         = st_reg.acknowledge;
   assign interrupt_clock_o     = st_reg.acknowledge;
   assign acknowledge_control_o = st_reg.acknowledge_control;
   assign timing_one_o          = st_reg.timing_one;
   assign timing_two_o          = st_reg.timing_two;
   assign phase_clock_gate_o    = st_reg.timing_one;
   assign address_in_o          = st_reg.timing_one & ~st_reg.timing_two;
   assign arith_clear_receive_o = address_in_o | st_reg.timing_two;
   assign bus_receive_gate_o    = address_in_o | in_t2;
   assign load_l_register_o     = address_in_o;
   // function ready only in period 4, where the gate lets phase clock through
   assign function_ready_o      = address_in_o & in_p4;
   assign clear_w_o             = function_ready_o & master_clock_pulse_i;
   // trap-in period 7 start is the second of the two half-cycle starts
   assign start_memory_clock_o  = clear_w_o
                                | (load_w_o);
   assign data_out_enable_o     = out_t2;
   assign bus_drive_o           = out_t2;
   assign bus_drive_gate_o      = out_t2;
   // trap-out strobe is cut short before the period ends so that function ready
   // and the data hold time are never violated at the controller
   assign data_ready_o          = st_reg.timing_two & st_reg.timing_one & in_p7
                                & (st_reg.dir_in | ~master_clock_pulse_i);
   assign data_in_enable_o      = in_t2;
   assign bus_receive_o         = in_t2;
   assign full_cycle_o          = ~in_t2;
   assign write_latch_o         = st_reg.write_latch;
   assign load_w_o              = data_ready_o & master_clock_pulse_i & in_t2;
   assign a_bus_o               = ~w_reg_bar_i & {WORD_W{data_out_enable_o}};

   // checks; the sequence advances only on master clock pulses
   logic [3:0] pulse_cnt;
   always_ff @(posedge sys_clk_i)
   begin
      if (clear_all || !st_reg.inhibit_clock)
         pulse_cnt <= 4'h0;
      else if (master_clock_pulse_i)
         pulse_cnt <= pulse_cnt + 4'h1;
   end

   trap_accept_a: assert property (@(posedge sys_clk_i) disable iff (clear_all)
      (st_reg.period == TDS_IDLE && master_clock_pulse_i && phase_clock_i && execute_phase_i
       && trap_request && !trap_inhibit) |=> (inhibit_clock_o && acknowledge_o))
      else $error("trap not accepted");
   halt_block_a: assert property (@(posedge sys_clk_i) disable iff (clear_all)
      (!inhibit_clock_o && halt_i && address_code_zero_i) |=> !inhibit_clock_o)
      else $error("trap taken during halt");
   ack_clock_a: assert property (@(posedge sys_clk_i) disable iff (clear_all)
      interrupt_clock_o == acknowledge_o && (acknowledge_o -> inhibit_clock_o))
      else $error("interrupt clock not following acknowledge");
   // a reset in mid-trap also drops inhibit clock, so only a natural end is timed
   seq_length_a: assert property (@(posedge sys_clk_i) disable iff (clear_all)
      ($fell(inhibit_clock_o) && !$past(clear_all)) |-> pulse_cnt == 4'h7)
      else $error("sequence not eight periods");
   inhibit_hold_a: assert property (@(posedge sys_clk_i) disable iff (clear_all)
      inhibit_clock_o |-> arith_bus_select_o && clock_suppress_o)
      else $error("bus select or clock suppress missing");
   ack_drop_a: assert property (@(posedge sys_clk_i) disable iff (clear_all)
      ($fell(acknowledge_o) && !$past(clear_all)) |-> st_reg.period == TDS_P8)
      else $error("acknowledge dropped outside period 8");
   ctrl_set_a: assert property (@(posedge sys_clk_i) disable iff (clear_all)
      $rose(acknowledge_control_o) |-> st_reg.period == TDS_P3 && timing_one_o)
      else $error("acknowledge control set out of step");
   fready_out_a: assert property (@(posedge sys_clk_i) disable iff (clear_all)
      function_ready_o |-> in_p4 && address_in_o)
      else $error("function ready outside period 4");
   mem_cycle_a: assert property (@(posedge sys_clk_i) disable iff (clear_all)
      clear_w_o |=> st_reg.period == TDS_P5)
      else $error("memory start not at end of period 4");
   in_start_a: assert property (@(posedge sys_clk_i) disable iff (clear_all)
      (clear_w_o && st_reg.dir_in) |-> start_memory_clock_o)
      else $error("trap-in period 4 memory start missing");
   out_gate_a: assert property (@(posedge sys_clk_i) disable iff (clear_all)
      (timing_two_o && !st_reg.dir_in) |-> data_out_enable_o && bus_drive_o
      && bus_drive_gate_o && arith_clear_receive_o)
      else $error("trap-out drive signals missing");
   phase_gate_a: assert property (@(posedge sys_clk_i) disable iff (clear_all)
      ($rose(timing_one_o) && timing_two_o) |-> st_reg.period == TDS_P6 && phase_clock_gate_o)
      else $error("timing one set again out of step");
   out_end_a: assert property (@(posedge sys_clk_i) disable iff (clear_all)
      st_reg.period == TDS_P8 |-> !timing_one_o && !timing_two_o && !interrupt_clock_o
      && !bus_drive_o)
      else $error("period 8 drive not dropped");
   in_gate_a: assert property (@(posedge sys_clk_i) disable iff (clear_all)
      (timing_two_o && st_reg.dir_in) |-> data_in_enable_o && bus_receive_o
      && !full_cycle_o && bus_receive_gate_o)
      else $error("trap-in receive signals missing");
   in_store_a: assert property (@(posedge sys_clk_i) disable iff (clear_all)
      load_w_o |-> start_memory_clock_o && write_latch_o && in_p7)
      else $error("store half cycle not started");
   in_end_a: assert property (@(posedge sys_clk_i) disable iff (clear_all)
      st_reg.period == TDS_P8 |-> !write_latch_o && !acknowledge_o)
      else $error("write latch held into period 8");
   two_starts_a: assert property (@(posedge sys_clk_i) disable iff (clear_all)
      load_w_o |-> !full_cycle_o)
      else $error("second start without half cycle");
   req_source_a: assert property (@(posedge sys_clk_i) disable iff (clear_all)
      (st_reg.period == TDS_IDLE && master_clock_pulse_i && !trap_request) |=> !inhibit_clock_o)
      else $error("trap taken without request");
   no_restart_a: assert property (@(posedge sys_clk_i) disable iff (clear_all)
      (inhibit_clock_o && !master_clock_pulse_i) |=> inhibit_clock_o)
      else $error("inhibit clock lost between pulses");
   addr_phase_a: assert property (@(posedge sys_clk_i) disable iff (clear_all)
      load_l_register_o |-> (st_reg.period == TDS_P3 || st_reg.period == TDS_P4))
      else $error("address load outside periods 3 and 4");
   mem_start_a: assert property (@(posedge sys_clk_i) disable iff (clear_all)
      clear_w_o |-> start_memory_clock_o && function_ready_o && in_p4)
      else $error("clear w without memory start");
   drive_window_a: assert property (@(posedge sys_clk_i) disable iff (clear_all)
      bus_drive_o |-> (st_reg.period inside {TDS_P5, TDS_P6, TDS_P7}) && !st_reg.dir_in)
      else $error("bus drive outside periods 5 to 7");
   write_hold_a: assert property (@(posedge sys_clk_i) disable iff (clear_all)
      $rose(write_latch_o) |-> st_reg.period == TDS_P6 ##0 write_latch_o [*1]
      ##1 (write_latch_o || st_reg.period == TDS_P7))
      else $error("write latch lost early");
   abus_gate_a: assert property (@(posedge sys_clk_i) disable iff (clear_all)
      !data_out_enable_o |-> a_bus_o == '0)
      else $error("a bus driven without data out enable");
   strobe_short_a: assert property (@(posedge sys_clk_i) disable iff (clear_all)
      (data_ready_o && !st_reg.dir_in) |-> !master_clock_pulse_i)
      else $error("trap-out data ready not shortened");

   trap_out_c: cover property (@(posedge sys_clk_i) disable iff (clear_all)
      $fell(inhibit_clock_o) && !$past(st_reg.dir_in));
   trap_in_c: cover property (@(posedge sys_clk_i) disable iff (clear_all)
      load_w_o);
   halt_block_c: cover property (@(posedge sys_clk_i) disable iff (clear_all)
      halt_i && address_code_zero_i && trap_request && master_clock_pulse_i);
   other_block_c: cover property (@(posedge sys_clk_i) disable iff (clear_all)
      other_inhibit_i && trap_request && master_clock_pulse_i);
   abort_c: cover property (@(posedge sys_clk_i)
      inhibit_clock_o && (halt_reset_i || system_reset_i));

endmodule

/* File: test/tds_controller_model.sv */
// model of the I/O device controller that asks the sequencer for trap transfers
// assumes start strobes from the bench, one clock wide, and the sequencer's data ready
`timescale 1ns/1ps

module tds_controller_model
(
   input  wire logic sys_clk_i,              // system clock
   input  wire logic reset_i,                // any reset, high
   input  wire logic start_out_i,            // ask for a trap-out
   input  wire logic start_in_i,             // ask for a trap-in
   input  wire logic data_ready_i,           // data ready from the sequencer
   input  wire logic function_ready_i,       // function ready from the sequencer
   output logic      data_phase_o,           // data word replaces address on E bus
   output logic      trap_output_request_o,  // trap-out request
   output logic      trap_input_request_o    // trap-in request
);
   logic strobe_seen_reg;

   // trap-in: function ready tells the controller to swap address for data
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i || !trap_input_request_o)
         data_phase_o <= 1'b0;
      else if (function_ready_i)
         data_phase_o <= 1'b1;
   end

   // the request is held until data ready has come and gone, never longer
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         trap_output_request_o <= 1'b0;
         trap_input_request_o  <= 1'b0;
         strobe_seen_reg       <= 1'b0;
      end
      else if (start_out_i || start_in_i)
      begin
         trap_output_request_o <= trap_output_request_o | start_out_i;
         trap_input_request_o  <= trap_input_request_o | start_in_i;
      end
      else if (data_ready_i)
         strobe_seen_reg <= 1'b1;
      else if (strobe_seen_reg)
      begin
         trap_output_request_o <= 1'b0;
         trap_input_request_o  <= 1'b0;
         strobe_seen_reg       <= 1'b0;
      end
   end
endmodule

/* File: test/testbench.sv */
// self-checking bench for the trap data transfer sequencer
// assumes the controller model in its own file and a master pulse every fourth clock
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin miscompares++; \
   $display("wrong value %s expected %h seen %h", nm, exp, got); end end

module testbench;
   import tds_pkg::*;
   logic sys_clk_i, reset_i, halt_reset_i, system_reset_i, halt_i, master_clock_pulse_i;
   logic phase_clock_i, execute_phase_i, address_code_zero_i, other_inhibit_i;
   logic trap_output_request_i, trap_input_request_i, start_out, start_in;
   logic inhibit_clock_o, arith_bus_select_o, clock_suppress_o, acknowledge_o;
   logic interrupt_clock_o, acknowledge_control_o, timing_one_o, timing_two_o;
   logic phase_clock_gate_o, address_in_o, arith_clear_receive_o, bus_receive_gate_o;
   logic load_l_register_o, function_ready_o, clear_w_o, start_memory_clock_o;
   logic data_out_enable_o, bus_drive_o, bus_drive_gate_o, data_ready_o;
   logic data_in_enable_o, bus_receive_o, full_cycle_o, write_latch_o, load_w_o;
   logic [TDS_WORD_W-1:0] w_reg_bar_i, a_bus_o;
   logic [1:0] pulse_cnt;
   logic data_phase;
   int miscompares, num_checks;

   tds_sequencer dut_u (.*);
   tds_controller_model partner_u (.sys_clk_i(sys_clk_i),
      .reset_i(reset_i | halt_reset_i | system_reset_i), .start_out_i(start_out),
      .start_in_i(start_in), .data_ready_i(data_ready_o),
      .function_ready_i(function_ready_o), .data_phase_o(data_phase),
      .trap_output_request_o(trap_output_request_i),
      .trap_input_request_o(trap_input_request_i));

   initial
   begin
      sys_clk_i = 1'b0;
      forever #4 sys_clk_i = ~sys_clk_i;
   end

   // one master pulse per four clocks marks each period boundary
   always @(posedge sys_clk_i)
   begin
      pulse_cnt <= pulse_cnt + 2'h1;
      master_clock_pulse_i <= (pulse_cnt == 2'h3);
   end

   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // checks the pulses of the closing cycle, then moves into the next period
   task automatic wait_pulse(input int p, input logic din);
      int n;
      begin
         n = 0;
         while (master_clock_pulse_i !== 1'b1 && n < 20)
         begin
            @(negedge sys_clk_i);
            n++;
         end
         if (n >= 20)
         begin
            miscompares++;
            test_done();
         end
         `CHK("clear_w", p == 4, clear_w_o)
         `CHK("start_memory_clock", (p == 4) || (p == 7 && din), start_memory_clock_o)
         `CHK("load_w", p == 7 && din, load_w_o)
         if (p == 7)
            `CHK("data_ready_end", din, data_ready_o)
         @(posedge sys_clk_i);
         @(negedge sys_clk_i);
      end
   endtask

   task automatic check_period(input int p, input logic din, input logic [TDS_WORD_W-1:0] wb);
      logic t1, t2;
      begin
         t1 = (p == 3 || p == 4 || p == 6 || p == 7);
         t2 = (p >= 5 && p <= 7);
         `CHK("inhibit_clock", 1'b1, inhibit_clock_o)
         `CHK("arith_bus_select", 1'b1, arith_bus_select_o)
         `CHK("acknowledge", p <= 7, acknowledge_o)
         `CHK("interrupt_clock", p <= 7, interrupt_clock_o)
         `CHK("acknowledge_control", p >= 3 && p <= 7, acknowledge_control_o)
         `CHK("clock_suppress", 1'b1, clock_suppress_o)
         `CHK("bus_receive_gate", p == 3 || p == 4 || (t2 & din), bus_receive_gate_o)
         `CHK("bus_drive_gate", t2 & ~din, bus_drive_gate_o)
         `CHK("data_in_enable", t2 & din, data_in_enable_o)
         `CHK("data_phase", din && p >= 5, data_phase)
         `CHK("timing_one", t1, timing_one_o)
         `CHK("phase_clock_gate", t1, phase_clock_gate_o)
         `CHK("timing_two", t2, timing_two_o)
         `CHK("address_in", p == 3 || p == 4, address_in_o)
         `CHK("load_l_register", p == 3 || p == 4, load_l_register_o)
         `CHK("arith_clear", p >= 3 && p <= 7, arith_clear_receive_o)
         `CHK("function_ready", p == 4, function_ready_o)
         `CHK("bus_drive", t2 & ~din, bus_drive_o)
         `CHK("data_out_enable", t2 & ~din, data_out_enable_o)
         `CHK("bus_receive", t2 & din, bus_receive_o)
         `CHK("full_cycle", ~(t2 & din), full_cycle_o)
         `CHK("write_latch", din && (p == 6 || p == 7), write_latch_o)
         `CHK("data_ready", p == 7, data_ready_o)
         `CHK("a_bus", (t2 & ~din) ? ~wb : '0, a_bus_o)
      end
   endtask

   task automatic run_trap(input logic din, input logic [TDS_WORD_W-1:0] wb, input int stop);
      int n;
      begin
         @(posedge sys_clk_i);
         w_reg_bar_i <= wb;
         start_out <= ~din;
         start_in <= din;
         @(posedge sys_clk_i);
         start_out <= 1'b0;
         start_in <= 1'b0;
         @(negedge sys_clk_i);
         for (n = 0; n < 40 && inhibit_clock_o !== 1'b1; n++)
            @(negedge sys_clk_i);
         `CHK("accepted", 1'b1, inhibit_clock_o)
         for (n = 2; n <= stop; n++)
         begin
            check_period(n, din, wb);
            wait_pulse(n, din);
         end
      end
   endtask

   // a trap refused under halt with address code zero, other inhibit and no phase clock, then taken once they clear
   task automatic refusals;
      int i, k;
      for (i = 0; i < 3; i++)
      begin
         @(posedge sys_clk_i);
         halt_i <= (i == 0);
         address_code_zero_i <= (i == 0);
         other_inhibit_i <= (i == 1);
         phase_clock_i <= (i != 2);
         start_out <= 1'b1;
         @(posedge sys_clk_i);
         start_out <= 1'b0;
         @(negedge sys_clk_i);
         for (k = 0; k < 3; k++)
            wait_pulse(0, 1'b0);
         `CHK("refused", 1'b0, inhibit_clock_o)
      end
      @(posedge sys_clk_i);
      halt_i <= 1'b0;
      address_code_zero_i <= 1'b0;
      phase_clock_i <= 1'b1;
      run_trap(1'b0, 18'h15555, 8);
      `CHK("trap_done", 1'b0, inhibit_clock_o)
   endtask

   // reset in mid-trap clears the whole sequencer
   task automatic abort_trap(input logic use_halt);
      run_trap(1'b1, 18'h0f0f0, 5);
      @(posedge sys_clk_i);
      halt_reset_i <= use_halt;
      system_reset_i <= ~use_halt;
      @(posedge sys_clk_i);
      halt_reset_i <= 1'b0;
      system_reset_i <= 1'b0;
      @(negedge sys_clk_i);
      `CHK("abort_inhibit", 1'b0, inhibit_clock_o)
      `CHK("abort_t1", 1'b0, timing_one_o | timing_two_o | write_latch_o)
      `CHK("abort_full_cycle", 1'b1, full_cycle_o)
   endtask

   initial
   begin
      {reset_i, halt_reset_i, system_reset_i, halt_i, address_code_zero_i} = 5'h10;
      {other_inhibit_i, start_out, start_in, master_clock_pulse_i} = 4'h0;
      {phase_clock_i, execute_phase_i, pulse_cnt} = 4'hc;
      w_reg_bar_i = '0;
      miscompares = 0;
      num_checks = 0;
      repeat (10) @(posedge sys_clk_i);
      reset_i <= 1'b0;
      run_trap(1'b0, 18'h2aaaa, 8);
      `CHK("out_done", 1'b0, inhibit_clock_o)
      run_trap(1'b1, 18'h3c3c3, 8);
      `CHK("in_done", 1'b0, inhibit_clock_o)
      refusals();
      abort_trap(1'b0);
      abort_trap(1'b1);
      test_done();
   end
endmodule
